// ==== bcx_pkg.sv ====
// shared types and constants of the branch and cpu control execution block
package bcx_pkg;

	// widths
	localparam int unsigned CYC_W = 8;
	localparam int unsigned WAIT_W = 4;

	// instruction kinds
	typedef enum logic [4:0] {
		K_JUMP_UNCONDITIONAL_ABS = 5'h00,
		K_JUMP_UNCONDITIONAL_REL = 5'h01,
		K_JUMP_UNCONDITIONAL_AX = 5'h02,
		K_BRANCH_ON_CARRY = 5'h03,
		K_BRANCH_ON_NO_CARRY = 5'h04,
		K_BRANCH_ON_ZERO = 5'h05,
		K_BRANCH_ON_NONZERO = 5'h06,
		K_BRANCH_IF_BIT_SET = 5'h07,
		K_BRANCH_IF_BIT_CLEAR = 5'h08,
		K_BRANCH_TEST_AND_CLEAR = 5'h09,
		K_DECREMENT_BRANCH_NONZERO = 5'h0a,
		K_BANK_SELECT = 5'h0b,
		K_NO_OPERATION_INSTR = 5'h0c,
		K_INTERRUPT_ENABLE_INSTR = 5'h0d,
		K_INTERRUPT_DISABLE_INSTR = 5'h0e,
		K_LIGHT_STANDBY = 5'h0f,
		K_DEEP_STANDBY = 5'h10
	} bcx_kind_e;

	// operand places
	typedef enum logic [2:0] {
		M_NONE = 3'h0,
		M_SADDR = 3'h1,
		M_SFR = 3'h2,
		M_ACC = 3'h3,
		M_PSW = 3'h4,
		M_HL = 3'h5,
		M_REG_B = 3'h6,
		M_REG_C = 3'h7
	} bcx_mode_e;

	// issued instruction with its fetched operand byte
	typedef struct packed {
		bcx_kind_e kind;
		bcx_mode_e mode;
		logic [2:0] bit_idx;
		logic [7:0] signed_displacement;
		logic [15:0] addr16;
		logic [15:0] pc;
		logic [7:0] opnd;
		logic hs_ram;
		logic [WAIT_W-1:0] rd_wait;
		logic [WAIT_W-1:0] wr_wait;
	} bcx_instr_s;

	// working registers of the core
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] x;
		logic [7:0] b;
		logic [7:0] c;
	} bcx_regs_s;

	// completion record
	typedef struct packed {
		logic [15:0] pc;
		logic [2:0] len;
		logic [CYC_W-1:0] cycles;
		logic taken;
		logic wb_en;
		bcx_mode_e wb_mode;
		logic [7:0] wb_data;
	} bcx_result_s;

	// status word fields
	localparam int unsigned PSW_CARRY = 0;
	localparam int unsigned PSW_BANK_LO = 3;
	localparam int unsigned PSW_AUX_CARRY = 4;
	localparam int unsigned PSW_BANK_HI = 5;
	localparam int unsigned PSW_ZERO = 6;
	localparam int unsigned PSW_IE = 7;
	localparam logic [7:0] PSW_RESET = 8'h00;

	// instruction lengths in bytes
	localparam logic [2:0] LEN_1 = 3'h1;
	localparam logic [2:0] LEN_2 = 3'h2;
	localparam logic [2:0] LEN_3 = 3'h3;
	localparam logic [2:0] LEN_4 = 3'h4;

	// clock counts
	localparam logic [CYC_W-1:0] CYC_NOP = 8'h02;
	localparam logic [CYC_W-1:0] CYC_SEL = 8'h04;
	localparam logic [CYC_W-1:0] CYC_SHORT = 8'h06;
	localparam logic [CYC_W-1:0] CYC_BIT_FAST = 8'h08;
	localparam logic [CYC_W-1:0] CYC_BIT_SLOW = 8'h09;
	localparam logic [CYC_W-1:0] CYC_MEM_FAST = 8'h0a;
	localparam logic [CYC_W-1:0] CYC_MEM_SLOW = 8'h0b;
	localparam logic [CYC_W-1:0] CYC_CLR_SLOW = 8'h0c;

endpackage

// ==== bcx_branch_exec.sv ====
// execution of branch, bit-test branch, decrement-branch and cpu control instructions
`timescale 1ns/1ps
module bcx_branch_exec (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// instruction issue
	input wire logic i_start,
	input wire bcx_pkg::bcx_instr_s i_instr,
	input wire bcx_pkg::bcx_regs_s i_regs,
	// status word load from the rest of the core
	input wire logic i_psw_we,
	input wire logic [7:0] i_psw_wdata,
	// standby release
	input wire logic i_wake,
	// completion
	output logic o_busy,
	output logic o_done,
	output bcx_pkg::bcx_result_s o_result,
	// core state
	output logic [7:0] o_psw,
	output logic o_halt,
	output logic o_stop
);

	typedef enum logic [1:0] {
		BCX_IDLE = 2'h0,
		BCX_EXEC = 2'h1
	} bcx_state_e;

	// length in bytes of each form
	function automatic logic [2:0] instr_len(input bcx_pkg::bcx_kind_e k, input bcx_pkg::bcx_mode_e md);
		logic [2:0] l;
		l = bcx_pkg::LEN_2;
		case (k)
			bcx_pkg::K_JUMP_UNCONDITIONAL_ABS:
				l = bcx_pkg::LEN_3;
			bcx_pkg::K_NO_OPERATION_INSTR:
				l = bcx_pkg::LEN_1;
			bcx_pkg::K_BRANCH_IF_BIT_SET:
				l = (md == bcx_pkg::M_SFR) ? bcx_pkg::LEN_4 : bcx_pkg::LEN_3;
			bcx_pkg::K_BRANCH_IF_BIT_CLEAR, bcx_pkg::K_BRANCH_TEST_AND_CLEAR:
			begin
				case (md)
					bcx_pkg::M_SADDR, bcx_pkg::M_SFR, bcx_pkg::M_PSW:
						l = bcx_pkg::LEN_4;
					default:
						l = bcx_pkg::LEN_3;
				endcase
			end
			bcx_pkg::K_DECREMENT_BRANCH_NONZERO:
				l = (md == bcx_pkg::M_SADDR) ? bcx_pkg::LEN_3 : bcx_pkg::LEN_2;
			default:
				l = bcx_pkg::LEN_2;
		endcase
		return l;
	endfunction

	// clock count for internal rom fetch, fast column for high-speed ram or no data access
	function automatic logic [7:0] instr_cycles(input bcx_pkg::bcx_instr_s ins);
		logic [7:0] c;
		logic [7:0] n;
		logic [7:0] m;
		logic fast;
		n = {4'h0, ins.rd_wait};
		m = {4'h0, ins.wr_wait};
		fast = ins.hs_ram;
		c = bcx_pkg::CYC_SHORT;
		case (ins.kind)
			bcx_pkg::K_JUMP_UNCONDITIONAL_AX:
				c = bcx_pkg::CYC_BIT_FAST;
			bcx_pkg::K_NO_OPERATION_INSTR:
				c = bcx_pkg::CYC_NOP;
			bcx_pkg::K_BANK_SELECT:
				c = bcx_pkg::CYC_SEL;
			bcx_pkg::K_BRANCH_IF_BIT_SET, bcx_pkg::K_BRANCH_IF_BIT_CLEAR:
			begin
				case (ins.mode)
					bcx_pkg::M_SADDR:
						if (ins.kind == bcx_pkg::K_BRANCH_IF_BIT_SET)
							c = fast ? bcx_pkg::CYC_BIT_FAST : bcx_pkg::CYC_BIT_SLOW;
						else
							c = fast ? bcx_pkg::CYC_MEM_FAST : bcx_pkg::CYC_MEM_SLOW;
					bcx_pkg::M_SFR:
						c = bcx_pkg::CYC_MEM_SLOW;
					bcx_pkg::M_PSW:
						if (ins.kind == bcx_pkg::K_BRANCH_IF_BIT_SET)
							c = bcx_pkg::CYC_BIT_SLOW;
						else
							c = bcx_pkg::CYC_MEM_SLOW;
					bcx_pkg::M_HL:
						c = fast ? bcx_pkg::CYC_MEM_FAST : bcx_pkg::CYC_MEM_SLOW + n;
					default:
						c = bcx_pkg::CYC_BIT_FAST;
				endcase
			end
			bcx_pkg::K_BRANCH_TEST_AND_CLEAR:
			begin
				case (ins.mode)
					bcx_pkg::M_SADDR:
						c = fast ? bcx_pkg::CYC_MEM_FAST : bcx_pkg::CYC_CLR_SLOW;
					bcx_pkg::M_SFR, bcx_pkg::M_PSW:
						c = bcx_pkg::CYC_CLR_SLOW;
					bcx_pkg::M_HL:
						c = fast ? bcx_pkg::CYC_MEM_FAST : bcx_pkg::CYC_CLR_SLOW + n + m;
					default:
						c = bcx_pkg::CYC_BIT_FAST;
				endcase
			end
			bcx_pkg::K_DECREMENT_BRANCH_NONZERO:
			begin
				if (ins.mode == bcx_pkg::M_SADDR)
					c = fast ? bcx_pkg::CYC_BIT_FAST : bcx_pkg::CYC_MEM_FAST;
				else
					c = bcx_pkg::CYC_SHORT;
			end
			default:
				c = bcx_pkg::CYC_SHORT;
		endcase
		return c;
	endfunction

	bcx_state_e state_q;
	logic [7:0] cnt_q;
	logic [7:0] psw_q;
	logic halt_q;
	logic stop_q;
	logic done_q;
	bcx_pkg::bcx_result_s res_q;
	bcx_pkg::bcx_result_s pend_q;
	logic pend_psw_we_q;
	logic [7:0] pend_psw_q;
	logic pend_halt_q;
	logic pend_stop_q;

	logic accept;
	logic commit;
	logic [2:0] len;
	logic [7:0] src;
	logic bit_val;
	logic [7:0] cleared;
	logic [7:0] dec;
	logic [15:0] seq_pc;
	logic [15:0] rel_pc;
	bcx_pkg::bcx_result_s nxt;
	logic nxt_psw_we;
	logic [7:0] nxt_psw;

	// handshake: a start is taken only while idle
	assign o_busy = (state_q != BCX_IDLE);
	assign accept = i_start && (state_q == BCX_IDLE);
	assign commit = (state_q == BCX_EXEC) && (cnt_q == 8'h00);

	// operand selection and bit arithmetic
	always_comb
	begin
		len = instr_len(i_instr.kind, i_instr.mode);
		case (i_instr.mode)
			bcx_pkg::M_ACC:
				src = i_regs.a;
			bcx_pkg::M_PSW:
				src = psw_q;
			bcx_pkg::M_REG_B:
				src = i_regs.b;
			bcx_pkg::M_REG_C:
				src = i_regs.c;
			default:
				src = i_instr.opnd;
		endcase
		bit_val = src[i_instr.bit_idx];
		cleared = src & ~(8'h01 << i_instr.bit_idx);
		dec = src - 8'h01;
		seq_pc = i_instr.pc + {13'h0000, len};
		rel_pc = seq_pc + {{8{i_instr.signed_displacement[7]}}, i_instr.signed_displacement};
	end

	// outcome of the issued instruction
	always_comb
	begin
		nxt = '0;
		nxt.len = len;
		nxt.cycles = instr_cycles(i_instr);
		nxt.wb_mode = i_instr.mode;
		nxt_psw_we = 1'b0;
		nxt_psw = psw_q;
		case (i_instr.kind)
			bcx_pkg::K_JUMP_UNCONDITIONAL_ABS, bcx_pkg::K_JUMP_UNCONDITIONAL_REL, bcx_pkg::K_JUMP_UNCONDITIONAL_AX:
				nxt.taken = 1'b1;
			bcx_pkg::K_BRANCH_ON_CARRY:
				nxt.taken = psw_q[bcx_pkg::PSW_CARRY];
			bcx_pkg::K_BRANCH_ON_NO_CARRY:
				nxt.taken = !psw_q[bcx_pkg::PSW_CARRY];
			bcx_pkg::K_BRANCH_ON_ZERO:
				nxt.taken = psw_q[bcx_pkg::PSW_ZERO];
			bcx_pkg::K_BRANCH_ON_NONZERO:
				nxt.taken = !psw_q[bcx_pkg::PSW_ZERO];
			bcx_pkg::K_BRANCH_IF_BIT_SET:
				nxt.taken = bit_val;
			bcx_pkg::K_BRANCH_IF_BIT_CLEAR:
				nxt.taken = !bit_val;
			bcx_pkg::K_BRANCH_TEST_AND_CLEAR:
			begin
				nxt.taken = bit_val;
				if (i_instr.mode == bcx_pkg::M_PSW)
				begin
					nxt_psw_we = bit_val;
					nxt_psw = cleared;
				end
				else
				begin
					nxt.wb_en = bit_val;
					nxt.wb_data = cleared;
				end
			end
			bcx_pkg::K_DECREMENT_BRANCH_NONZERO:
			begin
				nxt.wb_en = 1'b1;
				nxt.wb_data = dec;
				nxt.taken = (dec != 8'h00);
			end
			bcx_pkg::K_BANK_SELECT:
			begin
				nxt_psw_we = 1'b1;
				nxt_psw[bcx_pkg::PSW_BANK_HI] = i_instr.opnd[1];
				nxt_psw[bcx_pkg::PSW_BANK_LO] = i_instr.opnd[0];
			end
			bcx_pkg::K_INTERRUPT_ENABLE_INSTR:
			begin
				nxt_psw_we = 1'b1;
				nxt_psw[bcx_pkg::PSW_IE] = 1'b1;
			end
			bcx_pkg::K_INTERRUPT_DISABLE_INSTR:
			begin
				nxt_psw_we = 1'b1;
				nxt_psw[bcx_pkg::PSW_IE] = 1'b0;
			end
			default:
				nxt.taken = 1'b0;
		endcase
		// target selection
		case (i_instr.kind)
			bcx_pkg::K_JUMP_UNCONDITIONAL_ABS:
				nxt.pc = i_instr.addr16;
			bcx_pkg::K_JUMP_UNCONDITIONAL_AX:
				nxt.pc = {i_regs.a, i_regs.x};
			default:
				nxt.pc = nxt.taken ? rel_pc : seq_pc;
		endcase
	end

	// sequencer: holds the instruction for its documented clock count
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= BCX_IDLE;
			cnt_q <= 8'h00;
		end
		else
		begin
			case (state_q)
				BCX_IDLE:
					if (accept)
					begin
						state_q <= BCX_EXEC;
						cnt_q <= nxt.cycles - 8'h01;
					end
				BCX_EXEC:
					if (commit)
						state_q <= BCX_IDLE;
					else
						cnt_q <= cnt_q - 8'h01;
				default:
					state_q <= BCX_IDLE;
			endcase
		end
	end

	// outcome captured at issue
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pend_q <= '0;
			pend_psw_we_q <= 1'b0;
			pend_psw_q <= bcx_pkg::PSW_RESET;
			pend_halt_q <= 1'b0;
			pend_stop_q <= 1'b0;
		end
		else if (accept)
		begin
			pend_q <= nxt;
			pend_psw_we_q <= nxt_psw_we;
			pend_psw_q <= nxt_psw;
			pend_halt_q <= (i_instr.kind == bcx_pkg::K_LIGHT_STANDBY);
			pend_stop_q <= (i_instr.kind == bcx_pkg::K_DEEP_STANDBY);
		end
	end

	// completion record and pulse
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			res_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= commit;
			if (commit)
				res_q <= pend_q;
		end
	end

	// status word: a completing status write wins over a load from the core
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			psw_q <= bcx_pkg::PSW_RESET;
		else if (commit && pend_psw_we_q)
			psw_q <= pend_psw_q;
		else if (i_psw_we)
			psw_q <= i_psw_wdata;
	end

	// standby modes: entry wins over a wake in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			halt_q <= 1'b0;
			stop_q <= 1'b0;
		end
		else
		begin
			if (commit && pend_halt_q)
				halt_q <= 1'b1;
			else if (i_wake)
				halt_q <= 1'b0;
			if (commit && pend_stop_q)
				stop_q <= 1'b1;
			else if (i_wake)
				stop_q <= 1'b0;
		end
	end

	// outputs
	assign o_done = done_q;
	assign o_result = res_q;
	assign o_psw = psw_q;
	assign o_halt = halt_q;
	assign o_stop = stop_q;

endmodule

// ==== bcx_branch_exec_monitor.sv ====
// assertion checker for the branch execution block
`timescale 1ns/1ps
module bcx_branch_exec_monitor (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// watched inputs
	input wire logic i_start,
	input wire bcx_pkg::bcx_instr_s i_instr,
	input wire bcx_pkg::bcx_regs_s i_regs,
	input wire logic i_psw_we,
	input wire logic [7:0] i_psw_wdata,
	input wire logic i_wake,
	// watched outputs
	input wire logic o_busy,
	input wire logic o_done,
	input wire bcx_pkg::bcx_result_s o_result,
	input wire logic [7:0] o_psw,
	input wire logic o_halt,
	input wire logic o_stop
);
	// accept of an issue request
	wire logic acc;
	assign acc = i_start && !o_busy;
	default clocking mon_cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	// completion timing, targets and status effects after an accept
	AST_REL_TIME:
	assert property (acc && i_instr.kind == bcx_pkg::K_JUMP_UNCONDITIONAL_REL
		|=> o_busy [*6] ##1 (o_done && o_result.cycles == 8'h06)) else $error("rel jump timing");
	AST_REL_PC:
	assert property (acc && i_instr.kind == bcx_pkg::K_JUMP_UNCONDITIONAL_REL |-> ##7 o_result.pc ==
		$past(i_instr.pc, 7) + 16'h0002 + {{8{$past(i_instr.signed_displacement[7], 7)}},
		$past(i_instr.signed_displacement, 7)}) else $error("rel jump target");
	AST_AX_PC:
	assert property (acc && i_instr.kind == bcx_pkg::K_JUMP_UNCONDITIONAL_AX
		|-> ##9 (o_done && o_result.pc == {$past(i_regs.a, 9), $past(i_regs.x, 9)})) else $error("ax jump");
	AST_EI_SET:
	assert property (acc && i_instr.kind == bcx_pkg::K_INTERRUPT_ENABLE_INSTR
		|-> ##7 o_psw[bcx_pkg::PSW_IE]) else $error("enable not set");
	AST_DI_CLR:
	assert property (acc && i_instr.kind == bcx_pkg::K_INTERRUPT_DISABLE_INSTR
		|-> ##7 !o_psw[bcx_pkg::PSW_IE]) else $error("enable not cleared");
	AST_BANK_SEL:
	assert property (acc && i_instr.kind == bcx_pkg::K_BANK_SELECT
		|-> ##5 {o_psw[5], o_psw[3]} == $past(i_instr.opnd[1:0], 5)) else $error("bank bits");
	AST_HALT_SET:
	assert property (acc && i_instr.kind == bcx_pkg::K_LIGHT_STANDBY |-> ##7 o_halt) else $error("no halt");
	AST_STOP_SET:
	assert property (acc && i_instr.kind == bcx_pkg::K_DEEP_STANDBY |-> ##7 o_stop) else $error("no stop");
	// completion pulse, wake and status load while no instruction completes
	AST_DONE_PULSE:
	assert property (o_done |=> !o_done) else $error("done longer than one cycle");
	AST_WAKE_CLR:
	assert property (i_wake && !o_busy |=> !o_halt && !o_stop) else $error("wake did not clear standby");
	AST_PSW_LOAD:
	assert property (i_psw_we && !o_busy |=> o_psw == $past(i_psw_wdata)) else $error("status load lost");
endmodule
bind bcx_branch_exec bcx_branch_exec_monitor bcx_branch_exec_monitor_inst (.i_clock, .i_rst_n, .i_start,
	.i_instr, .i_regs, .i_psw_we, .i_psw_wdata, .i_wake, .o_busy, .o_done, .o_result, .o_psw, .o_halt, .o_stop);

// ==== tb.sv ====
// self-checking testbench of the branch execution block
`timescale 1ns/1ps
module tb;
	// case row: kind, mode, bit, operand, fast, waits n/m, length, clocks, taken
	typedef struct packed {
		logic [4:0] k;
		logic [2:0] m;
		logic [2:0] b;
		logic [7:0] o;
		logic h;
		logic [7:0] nw;
		logic [2:0] l;
		logic [7:0] c;
		logic t;
	} bcx_row_s;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_start = 1'b0;
	bcx_pkg::bcx_instr_s i_instr = '0;
	bcx_pkg::bcx_regs_s i_regs = '{8'h12, 8'h34, 8'h01, 8'h02};
	logic i_psw_we = 1'b0;
	logic [7:0] i_psw_wdata = 8'h41;
	logic i_wake = 1'b0;
	logic o_busy;
	logic o_done;
	bcx_pkg::bcx_result_s o_result;
	logic [7:0] o_psw;
	logic o_halt;
	logic o_stop;
	int num_errors = 0;
	int total_checks = 0;
	bcx_row_s rows [31] = '{
		'{5'h01,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h1},
		'{5'h02,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h08,1'h1},
		'{5'h03,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0},
		'{5'h04,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h1},
		'{5'h05,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0},
		'{5'h06,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h1},
		'{5'h07,3'h1,3'h3,8'h08,1'h1,8'h00,3'h3,8'h08,1'h1},
		'{5'h07,3'h1,3'h3,8'h08,1'h0,8'h00,3'h3,8'h09,1'h1},
		'{5'h07,3'h2,3'h0,8'h01,1'h0,8'h00,3'h4,8'h0b,1'h1},
		'{5'h07,3'h3,3'h0,8'h00,1'h1,8'h00,3'h3,8'h08,1'h0},
		'{5'h08,3'h1,3'h3,8'h08,1'h1,8'h00,3'h4,8'h0a,1'h0},
		'{5'h08,3'h1,3'h3,8'hf7,1'h0,8'h00,3'h4,8'h0b,1'h1},
		'{5'h08,3'h4,3'h7,8'h00,1'h1,8'h00,3'h4,8'h0b,1'h1},
		'{5'h07,3'h5,3'h0,8'h01,1'h0,8'h30,3'h3,8'h0e,1'h1},
		'{5'h09,3'h5,3'h0,8'h01,1'h0,8'h23,3'h3,8'h11,1'h1},
		'{5'h0a,3'h6,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0},
		'{5'h0a,3'h1,3'h0,8'h01,1'h0,8'h00,3'h3,8'h0a,1'h0},
		'{5'h0a,3'h1,3'h0,8'h05,1'h1,8'h00,3'h3,8'h08,1'h1},
		'{5'h00,3'h0,3'h0,8'h00,1'h1,8'h00,3'h3,8'h06,1'h1},
		'{5'h0c,3'h0,3'h0,8'h00,1'h1,8'h00,3'h1,8'h02,1'h0},
		'{5'h07,3'h4,3'h0,8'h00,1'h1,8'h00,3'h3,8'h09,1'h0},
		'{5'h08,3'h2,3'h0,8'h00,1'h1,8'h00,3'h4,8'h0b,1'h1},
		'{5'h08,3'h3,3'h0,8'h00,1'h0,8'h00,3'h3,8'h08,1'h1},
		'{5'h08,3'h5,3'h0,8'h00,1'h1,8'h50,3'h3,8'h0a,1'h1},
		'{5'h09,3'h1,3'h3,8'h08,1'h1,8'h00,3'h4,8'h0a,1'h1},
		'{5'h09,3'h1,3'h3,8'h00,1'h0,8'h00,3'h4,8'h0c,1'h0},
		'{5'h09,3'h2,3'h0,8'h01,1'h1,8'h00,3'h4,8'h0c,1'h1},
		'{5'h0e,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0},
		'{5'h0b,3'h0,3'h0,8'h02,1'h1,8'h00,3'h2,8'h04,1'h0},
		'{5'h0d,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0},
		'{5'h09,3'h4,3'h7,8'h00,1'h1,8'h00,3'h4,8'h0c,1'h1}
	};
	// device under test
	bcx_branch_exec bcx_branch_exec_inst (.i_clock, .i_rst_n, .i_start, .i_instr, .i_regs, .i_psw_we,
		.i_psw_wdata, .i_wake, .o_busy, .o_done, .o_result, .o_psw, .o_halt, .o_stop);
	// free-running clock
	always #5 i_clock = ~i_clock;
	// compare one value
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// wait for completion, bounded
	task automatic wait_done;
		int i;
		for (i = 0; i < 40 && o_done !== 1'b1; i++)
			@(negedge i_clock);
		check(o_done, 16'h0001);
	endtask
	// issue one row and compare its completion
	task automatic run(input bcx_row_s r);
		i_instr = '{bcx_pkg::bcx_kind_e'(r.k), bcx_pkg::bcx_mode_e'(r.m), r.b, 8'hf0, 16'h2468, 16'h1000,
			r.o, r.h, r.nw[7:4], r.nw[3:0]};
		i_start = 1'b1;
		@(negedge i_clock);
		i_start = 1'b0;
		wait_done();
		check(o_result.pc, r.k == 5'h02 ? 16'h1234 : r.k == 5'h00 ? 16'h2468
			: (r.t ? 16'h0ff0 : 16'h1000) + r.l);
		check(o_result.len, r.l);
		check(o_result.cycles, r.c);
		if (r.k < 5'h0b)
			check(o_result.taken, r.t);
	endtask
	// table, then hand-written cases
	initial
	begin
		repeat (6) @(negedge i_clock);
		i_rst_n = 1'b1;
		foreach (rows[j])
			run(rows[j]);
		check(o_psw, 16'h0020);
		check(o_result.wb_en, 16'h0000);
		run('{5'h0d,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0});
		check(o_psw, 16'h00a0);
		run('{5'h0e,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0});
		check(o_psw, 16'h0020);
		run('{5'h0f,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0});
		run('{5'h10,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0});
		check({o_halt, o_stop}, 16'h0003);
		i_wake = 1'b1;
		i_psw_we = 1'b1;
		@(negedge i_clock);
		i_wake = 1'b0;
		i_psw_we = 1'b0;
		check({o_halt, o_stop}, 16'h0000);
		// a completing standby beats a wake in the same edge
		i_wake = 1'b1;
		run('{5'h0f,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0});
		check(o_halt, 16'h0001);
		i_wake = 1'b0;
		// a completing status write beats a load in the same edge
		i_psw_we = 1'b1;
		run('{5'h0d,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h0});
		check(o_psw, 16'h00c1);
		i_psw_we = 1'b0;
		run('{5'h03,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h1});
		run('{5'h05,3'h0,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h1});
		run('{5'h09,3'h3,3'h1,8'h00,1'h1,8'h00,3'h3,8'h08,1'h1});
		check({o_result.wb_mode, o_result.wb_en, o_result.wb_data}, 16'h0710);
		run('{5'h0a,3'h7,3'h0,8'h00,1'h1,8'h00,3'h2,8'h06,1'h1});
		check({o_result.wb_mode, o_result.wb_en, o_result.wb_data}, 16'h0f01);
		// a request while busy is ignored
		i_instr.kind = bcx_pkg::K_JUMP_UNCONDITIONAL_AX;
		i_start = 1'b1;
		@(negedge i_clock);
		i_instr.kind = bcx_pkg::K_JUMP_UNCONDITIONAL_REL;
		@(negedge i_clock);
		i_start = 1'b0;
		wait_done();
		check(o_result.cycles, 16'h0008);
		check(o_result.pc, 16'h1234);
		// reset in mid-instruction aborts it
		i_instr.kind = bcx_pkg::K_LIGHT_STANDBY;
		i_start = 1'b1;
		@(negedge i_clock);
		i_start = 1'b0;
		@(negedge i_clock);
		i_rst_n = 1'b0;
		@(negedge i_clock);
		check({o_busy, o_done, o_halt, o_stop, o_psw}, 16'h0000);
		check(o_result.cycles, 16'h0000);
		// first request right after release, the aborted standby must not appear
		i_rst_n = 1'b1;
		run(rows[0]);
		check({o_halt, o_stop, o_psw}, 16'h0000);
		tally_and_finish();
	end
	// watchdog against a hang
	initial
	begin
		#20000;
		num_errors++;
		tally_and_finish();
	end
endmodule
